// ### src/rtc_access_pkg.sv
// Shared constants, states and helpers for the serial memory access block.
package rtc_access_pkg;

    // ----------------------------------------------------------------
    // Addressing
    // ----------------------------------------------------------------
    localparam logic [6:0] TARGET_ADDR = 7'h6f;
    localparam logic [6:0] TK_FIRST    = 7'h00;
    localparam logic [6:0] TK_LAST     = 7'h1f;
    localparam logic [6:0] MEM_FIRST   = 7'h20;
    localparam logic [6:0] MEM_LAST    = 7'h5f;
    localparam logic [6:0] PTR_RESET   = 7'h00;
    localparam int         MEM_DEPTH   = 64;
    localparam int         MEM_AW      = 6;

    // ----------------------------------------------------------------
    // Bit counting and line reset values
    // ----------------------------------------------------------------
    localparam logic [3:0] BYTE_BITS   = 4'h8;
    localparam logic [3:0] LAST_TX_BIT = 4'h7;
    localparam logic [1:0] LINE_IDLE   = 2'h3;

    // ----------------------------------------------------------------
    // Protocol states
    // ----------------------------------------------------------------
    typedef enum logic [6:0] {
        ST_IDLE  = 7'h01,
        ST_CTRL  = 7'h02,
        ST_ADDR  = 7'h04,
        ST_WDATA = 7'h08,
        ST_ACK   = 7'h10,
        ST_RDATA = 7'h20,
        ST_RACK  = 7'h40
    } access_state_t;

    // Pointer advance stays inside the block it started in.
    function automatic logic [6:0] ptr_inc(input logic [6:0] p);
        return (p == TK_LAST) ? TK_FIRST : (p == MEM_LAST) ? MEM_FIRST : 7'(p + 7'h01);
    endfunction : ptr_inc

endpackage : rtc_access_pkg

// ### src/rtc_access_if.sv
// Interfaces between the access controller, line sampler and storage.
interface line_if;
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    modport sampler (output scl, sda, scl_rise, scl_fall, start, stop);
    modport user    (input  scl, sda, scl_rise, scl_fall, start, stop);
endinterface : line_if

interface mem_if;
    logic       we;
    logic [5:0] waddr;
    logic [7:0] wdata;
    logic [5:0] raddr;
    logic [7:0] rdata;
    modport ctrl  (output we, waddr, wdata, raddr, input rdata);
    modport store (input  we, waddr, wdata, raddr, output rdata);
endinterface : mem_if

// ### src/line_sampler.sv
// Three-stage sampler for the serial clock and data wires with event detection.
module line_sampler
    import rtc_access_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic reset,
    input  wire logic scl_in,
    input  wire logic sda_in,
    line_if.sampler   ln
);
    logic [1:0] pin;
    logic [1:0] s1_reg;
    logic [1:0] s2_reg;
    logic [1:0] s3_reg;
    logic [1:0] lvl_reg;
    logic [1:0] lvl_next;
    logic [1:0] prev_reg;

    assign pin = {sda_in, scl_in};

    // ----------------------------------------------------------------
    // Per-wire synchroniser; a level is taken only when two stages agree.
    // ----------------------------------------------------------------
    for (genvar g = 0; g < 2; g++) begin : g_wire
        always_comb begin
            lvl_next[g] = (s2_reg[g] == s3_reg[g]) ? s2_reg[g] : lvl_reg[g];
        end
        always_ff @(posedge core_clk) begin
            if (reset) begin
                s1_reg[g]   <= LINE_IDLE[g];
                s2_reg[g]   <= LINE_IDLE[g];
                s3_reg[g]   <= LINE_IDLE[g];
                lvl_reg[g]  <= LINE_IDLE[g];
                prev_reg[g] <= LINE_IDLE[g];
            end else begin
                s1_reg[g]   <= pin[g];
                s2_reg[g]   <= s1_reg[g];
                s3_reg[g]   <= s2_reg[g];
                lvl_reg[g]  <= lvl_next[g];
                prev_reg[g] <= lvl_reg[g];
            end
        end
    end

    // ----------------------------------------------------------------
    // Events
    // ----------------------------------------------------------------
    assign ln.scl      = lvl_reg[0];
    assign ln.sda      = lvl_reg[1];
    assign ln.scl_rise = lvl_reg[0] & ~prev_reg[0];
    assign ln.scl_fall = ~lvl_reg[0] & prev_reg[0];
    assign ln.start    = prev_reg[1] & ~lvl_reg[1] & lvl_reg[0] & prev_reg[0];
    assign ln.stop     = ~prev_reg[1] & lvl_reg[1] & lvl_reg[0] & prev_reg[0];

endmodule : line_sampler

// ### src/sram_store.sv
// General-purpose byte storage held in flip-flops.
module sram_store
    import rtc_access_pkg::*;
(
    input  wire logic core_clk,
    mem_if.store      mem
);
    logic [7:0] cell_reg [MEM_DEPTH];

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    // No reset term: contents are undefined after power-up by design. [R5]
    always_ff @(posedge core_clk) begin
        if (mem.we) begin
            cell_reg[mem.waddr] <= mem.wdata; // [R1]
        end
    end

    assign mem.rdata = cell_reg[mem.raddr];

endmodule : sram_store

// ### src/rtc_sram_i2c_access.sv
// Two-wire target giving byte access to timekeeping registers and user memory.
// Notes on behaviour
// R1 - Sixty-four bytes of user memory, separate from timekeeping registers.
// R2 - One control byte selects both blocks; bit zero is read/write direction.
// R3 - Timekeeping registers at 0x00..0x1F, user memory at 0x20..0x5F.
// R4 - Memory accesses never stall while timekeeping registers update.
// R5 - Memory contents are not cleared or preset by reset.
// R6 - Byte write: control, address into pointer, one data byte, stop.
// R7 - Address above 0x5F: no acknowledge for address or data, nothing stored.
// R8 - After a byte write the pointer holds the next address.
// R9 - Sequential write: each byte acknowledged, stored during acknowledge, pointer advanced.
// R10 - No limit on bytes in one sequential write.
// R11 - Pointer wraps 0x1F to 0x00 and 0x5F to 0x20.
// R12 - Pointer equals last accessed address plus one.
// R13 - Current read: acknowledge control, send byte, stop on master not-acknowledge.
// R14 - Random read: address write, repeated start, then read control byte.
// R15 - After a random read pointer points past the byte read.
// R16 - Master acknowledge requests next byte; not-acknowledge and stop end it.
// R17 - Pointer advances after every byte so a block reads out serially.
// R18 - Foreign control byte ignored without acknowledge; pointer unchanged.
module rtc_sram_i2c_access
    import rtc_access_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       reset,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    output logic            tk_wr,
    output logic [4:0]      tk_wr_addr,
    output logic [7:0]      tk_wdata,
    output logic [4:0]      tk_rd_addr,
    input  wire logic [7:0] tk_rdata
);
    import rtc_access_pkg::*;

    line_if ln ();
    mem_if  mem ();

    access_state_t state_reg;
    access_state_t state_next;
    access_state_t after_reg;
    access_state_t after_next;
    logic [3:0]    cnt_reg;
    logic [3:0]    cnt_next;
    logic [7:0]    shift_reg;
    logic [7:0]    shift_next;
    logic [6:0]    ptr_reg;
    logic [6:0]    ptr_next;
    logic          oe_reg;
    logic          oe_next;
    logic          refused_reg;
    logic          refused_next;
    logic          more_reg;
    logic          more_next;
    logic          wr_stb_reg;
    logic          wr_stb_next;
    logic [6:0]    waddr_reg;
    logic [6:0]    waddr_next;
    logic [7:0]    wdata_reg;
    logic [7:0]    wdata_next;
    logic          tx_load;
    logic          byte_end;
    logic          rx_phase;
    logic [7:0]    rd_byte;
    logic [6:0]    rd_off;
    logic [6:0]    wr_off;

    // ----------------------------------------------------------------
    // Submodules
    // ----------------------------------------------------------------
    line_sampler u_sampler (
        .core_clk (core_clk),
        .reset    (reset),
        .scl_in   (scl_in),
        .sda_in   (sda_in),
        .ln       (ln.sampler)
    );

    sram_store u_store (
        .core_clk (core_clk),
        .mem      (mem.store)
    );

    // ----------------------------------------------------------------
    // Storage routing
    // ----------------------------------------------------------------
    assign rd_off     = 7'(ptr_reg - MEM_FIRST);
    assign wr_off     = 7'(waddr_reg - MEM_FIRST);
    assign mem.raddr  = rd_off[5:0];
    assign mem.waddr  = wr_off[5:0];
    assign mem.wdata  = wdata_reg;
    assign mem.we     = wr_stb_reg && (waddr_reg >= MEM_FIRST); // [R3]
    assign tk_wr      = wr_stb_reg && (waddr_reg < MEM_FIRST); // [R3]
    assign tk_wr_addr = waddr_reg[4:0];
    assign tk_wdata   = wdata_reg;
    assign tk_rd_addr = ptr_reg[4:0];
    // Memory reads take no notice of timekeeping activity, so they never wait. [R4]
    assign rd_byte    = (ptr_reg < MEM_FIRST) ? tk_rdata : mem.rdata; // [R3] [R4]

    // Open-drain data: only ever pulled low.
    assign sda_out    = 1'b0;
    assign sda_oe     = oe_reg;

    assign rx_phase   = (state_reg == ST_CTRL) || (state_reg == ST_ADDR)
                        || (state_reg == ST_WDATA);
    assign byte_end   = rx_phase && ln.scl_fall && (cnt_reg == BYTE_BITS);

    // ----------------------------------------------------------------
    // Protocol sequencing
    // ----------------------------------------------------------------
    always_comb begin
        state_next   = state_reg;
        after_next   = after_reg;
        cnt_next     = cnt_reg;
        shift_next   = shift_reg;
        ptr_next     = ptr_reg;
        oe_next      = oe_reg;
        refused_next = refused_reg;
        more_next    = more_reg;
        wr_stb_next  = 1'b0;
        waddr_next   = waddr_reg;
        wdata_next   = wdata_reg;
        tx_load      = 1'b0;
        if (ln.stop) begin
            state_next = ST_IDLE; // [R13] [R16]
            oe_next    = 1'b0;
        end else if (ln.start) begin
            // A repeated start restarts decoding but keeps the pointer. [R14]
            state_next   = ST_CTRL;
            cnt_next     = 4'h0;
            oe_next      = 1'b0;
            refused_next = 1'b0;
        end else begin
            if (rx_phase && ln.scl_rise && (cnt_reg != BYTE_BITS)) begin
                shift_next = {shift_reg[6:0], ln.sda};
                cnt_next   = 4'(cnt_reg + 4'h1);
            end
            case (state_reg)
                ST_CTRL: begin
                    if (byte_end) begin
                        cnt_next = 4'h0;
                        if (shift_reg[7:1] == TARGET_ADDR) begin // [R2]
                            oe_next    = 1'b1;
                            state_next = ST_ACK;
                            after_next = shift_reg[0] ? ST_RDATA : ST_ADDR; // [R2] [R13]
                        end else begin
                            state_next = ST_IDLE; // [R18]
                        end
                    end
                end
                ST_ADDR: begin
                    if (byte_end) begin
                        cnt_next   = 4'h0;
                        state_next = ST_ACK;
                        after_next = ST_WDATA;
                        if (shift_reg <= {1'b0, MEM_LAST}) begin
                            ptr_next = shift_reg[6:0]; // [R6] [R14]
                            oe_next  = 1'b1;
                        end else begin
                            refused_next = 1'b1; // [R7]
                        end
                    end
                end
                ST_WDATA: begin
                    // Every byte is handled alike, so there is no length cutoff. [R10]
                    if (byte_end) begin
                        cnt_next   = 4'h0;
                        state_next = ST_ACK;
                        after_next = ST_WDATA;
                        if (!refused_reg) begin // [R7]
                            wr_stb_next = 1'b1; // [R6] [R9]
                            waddr_next  = ptr_reg;
                            wdata_next  = shift_reg;
                            ptr_next    = ptr_inc(ptr_reg); // [R8] [R11] [R17]
                            oe_next     = 1'b1; // [R9]
                        end
                    end
                end
                ST_ACK: begin
                    if (ln.scl_fall) begin
                        oe_next = 1'b0;
                        if (after_reg == ST_RDATA) begin
                            tx_load = 1'b1;
                        end else begin
                            state_next = after_reg;
                        end
                    end
                end
                ST_RDATA: begin
                    if (ln.scl_fall) begin
                        if (cnt_reg == LAST_TX_BIT) begin
                            oe_next    = 1'b0;
                            cnt_next   = 4'h0;
                            state_next = ST_RACK;
                        end else begin
                            shift_next = {shift_reg[6:0], 1'b0};
                            oe_next    = ~shift_reg[6];
                            cnt_next   = 4'(cnt_reg + 4'h1);
                        end
                    end
                end
                ST_RACK: begin
                    if (ln.scl_rise) begin
                        more_next = ~ln.sda;
                    end
                    if (ln.scl_fall) begin
                        if (more_reg) begin
                            tx_load = 1'b1; // [R16]
                        end else begin
                            state_next = ST_IDLE; // [R13] [R16]
                        end
                    end
                end
                ST_IDLE: begin
                    state_next = ST_IDLE;
                end
                default: begin
                    state_next = ST_IDLE;
                    oe_next    = 1'b0;
                end
            endcase
            if (tx_load) begin
                shift_next = rd_byte;
                ptr_next   = ptr_inc(ptr_reg); // [R12] [R15] [R17] [R11]
                oe_next    = ~rd_byte[7];
                cnt_next   = 4'h0;
                state_next = ST_RDATA;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_reg   <= ST_IDLE;
            after_reg   <= ST_IDLE;
            cnt_reg     <= 4'h0;
            shift_reg   <= 8'h00;
            ptr_reg     <= PTR_RESET;
            oe_reg      <= 1'b0;
            refused_reg <= 1'b0;
            more_reg    <= 1'b0;
            wr_stb_reg  <= 1'b0;
            waddr_reg   <= PTR_RESET;
            wdata_reg   <= 8'h00;
        end else begin
            state_reg   <= state_next;
            after_reg   <= after_next;
            cnt_reg     <= cnt_next;
            shift_reg   <= shift_next;
            ptr_reg     <= ptr_next;
            oe_reg      <= oe_next;
            refused_reg <= refused_next;
            more_reg    <= more_next;
            wr_stb_reg  <= wr_stb_next;
            waddr_reg   <= waddr_next;
            wdata_reg   <= wdata_next;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    a_ctrl_match_ack: assert property ( // [R2]
        (byte_end && state_reg == ST_CTRL && shift_reg[7:1] == TARGET_ADDR && !ln.stop
         && !ln.start) |=> (oe_reg && state_reg == ST_ACK))
        else $error("Matching control byte was not acknowledged.");

    a_foreign_ignored: assert property ( // [R18]
        (byte_end && state_reg == ST_CTRL && shift_reg[7:1] != TARGET_ADDR && !ln.stop
         && !ln.start) |=> (state_reg == ST_IDLE && !oe_reg && ptr_reg == $past(ptr_reg)))
        else $error("Foreign control byte was not ignored.");

    a_bad_addr_nack: assert property ( // [R7]
        (byte_end && state_reg == ST_ADDR && shift_reg > {1'b0, MEM_LAST} && !ln.stop
         && !ln.start) |=> (!oe_reg && refused_reg)[*2])
        else $error("Out of range address was acknowledged.");

    a_refused_no_store: assert property ( // [R7]
        refused_reg |-> !wr_stb_reg && !oe_reg)
        else $error("Refused write stored or acknowledged data.");

    a_write_ptr_next: assert property ( // [R8]
        wr_stb_reg |-> ptr_reg == ptr_inc(waddr_reg))
        else $error("Pointer does not follow the byte written.");

    a_mem_wrap: assert property ( // [R11]
        (wr_stb_reg && waddr_reg == MEM_LAST) |-> ptr_reg == MEM_FIRST)
        else $error("Memory block pointer did not wrap.");

    a_block_range: assert property ( // [R3]
        wr_stb_reg |-> (tk_wr && waddr_reg <= TK_LAST)
                       || (mem.we && waddr_reg >= MEM_FIRST && waddr_reg <= MEM_LAST))
        else $error("Write strobe outside its block range.");

    a_read_advance: assert property ( // [R12]
        (tx_load && !ln.stop && !ln.start) |=> (ptr_reg == ptr_inc($past(ptr_reg))
                                                && state_reg == ST_RDATA))
        else $error("Read did not advance the pointer.");

    a_stop_release: assert property ( // [R13]
        ln.stop |=> (state_reg == ST_IDLE && !oe_reg))
        else $error("Stop did not end the transfer.");

    a_nack_ends_read: assert property ( // [R16]
        (state_reg == ST_RACK && !more_reg && ln.scl_fall && !ln.stop && !ln.start)
        |=> state_reg == ST_IDLE ##1 !oe_reg)
        else $error("Master not-acknowledge did not end the read.");

    c_byte_write: cover property (wr_stb_reg && mem.we);
    c_tk_write: cover property (wr_stb_reg && tk_wr);
    c_seq_read: cover property (state_reg == ST_RACK && more_reg && ln.scl_fall);
    c_refused: cover property (refused_reg && state_reg == ST_ACK);

endmodule : rtc_sram_i2c_access

// ### bench/i2c_master_model.sv
// Behavioural two-wire bus master that drives the serial clock and data wires.
module i2c_master_model (
    input  wire logic core_clk,
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda_drv
);
    timeunit 1ns;
    timeprecision 100ps;

    // ----------------------------------------------------------------
    // Line timing
    // ----------------------------------------------------------------
    // One bit is 12 cycles low and 4 high, 160 ns in all.
    // Data moves 60 ns after the clock falls, so setup and hold are both 60 ns.
    // The clock stands still between frames, as a real master leaves it.
    initial begin
        scl     = 1'b1;
        sda_drv = 1'b1;
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask : wait_cyc

    // Serves as start and repeated start alike.
    task automatic start_cond();
        wait_cyc(6);
        sda_drv = 1'b1;
        wait_cyc(6);
        scl = 1'b1;
        wait_cyc(4);
        sda_drv = 1'b0;
        wait_cyc(4);
        scl = 1'b0;
    endtask : start_cond

    task automatic stop_cond();
        wait_cyc(6);
        sda_drv = 1'b0;
        wait_cyc(6);
        scl = 1'b1;
        wait_cyc(4);
        sda_drv = 1'b1;
        wait_cyc(8);
    endtask : stop_cond

    task automatic one_bit(input logic b, output logic s);
        wait_cyc(6);
        sda_drv = b;
        wait_cyc(6);
        scl = 1'b1;
        wait_cyc(2);
        s = sda_line;
        wait_cyc(2);
        scl = 1'b0;
    endtask : one_bit

    // Eight bits most significant first, then the acknowledge bit.
    task automatic xfer(input  logic [7:0] d,
                        input  logic       ackbit,
                        output logic [7:0] q,
                        output logic       ack_seen);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            one_bit(d[i], q[i]);
        end
        one_bit(ackbit, s);
        ack_seen = ~s;
    endtask : xfer

endmodule : i2c_master_model

// ### bench/rtc_sram_i2c_access_test.sv
// Self-checking bench for the serial access block with a master model.
module rtc_sram_i2c_access_test;
    timeunit 1ns;
    timeprecision 100ps;
    import rtc_access_pkg::*;

    // ----------------------------------------------------------------
    // Signals and reference state
    // ----------------------------------------------------------------
    logic       core_clk;
    logic       reset;
    logic       scl;
    logic       sda_drv;
    wire logic  sda_line;
    logic       sda_out;
    logic       sda_oe;
    logic       tk_wr;
    logic [4:0] tk_wr_addr;
    logic [7:0] tk_wdata;
    logic [4:0] tk_rd_addr;
    wire logic [7:0] tk_rdata;
    logic [7:0] tk_regs [32];
    logic [7:0] ref_mem [128];
    logic [6:0] ref_ptr;
    int         fail_count;
    int         comparisons;

    // Pulled-up wire: low when either party pulls it.
    assign sda_line = sda_drv & (~sda_oe | sda_out);
    assign tk_rdata = tk_regs[tk_rd_addr];

    always @(posedge core_clk) begin
        if (tk_wr === 1'b1) begin
            tk_regs[tk_wr_addr] <= tk_wdata;
        end
    end

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    i2c_master_model master (
        .core_clk (core_clk),
        .sda_line (sda_line),
        .scl      (scl),
        .sda_drv  (sda_drv)
    );

    rtc_sram_i2c_access dut (
        .core_clk   (core_clk),
        .reset      (reset),
        .scl_in     (scl),
        .sda_in     (sda_line),
        .sda_out    (sda_out),
        .sda_oe     (sda_oe),
        .tk_wr      (tk_wr),
        .tk_wr_addr (tk_wr_addr),
        .tk_wdata   (tk_wdata),
        .tk_rd_addr (tk_rd_addr),
        .tk_rdata   (tk_rdata)
    );

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [6:0] nxt(input logic [6:0] p);
        if (p == 7'h1f) return 7'h00;
        if (p == 7'h5f) return 7'h20;
        return p + 7'h01;
    endfunction : nxt

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
            fail_count++;
        end
    endtask : check

    task automatic send(input logic [7:0] d, input logic exp_ack);
        logic [7:0] q;
        logic       a;
        master.xfer(d, 1'b1, q, a);
        check("acknowledge", {7'h00, a}, {7'h00, exp_ack});
    endtask : send

    task automatic write_seq(input logic [6:0] addr, input int n);
        logic [7:0] d;
        master.start_cond();
        send(8'hde, 1'b1);
        send({1'b0, addr}, 1'b1);
        ref_ptr = addr;
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            send(d, 1'b1);
            ref_mem[ref_ptr] = d;
            ref_ptr = nxt(ref_ptr);
        end
        master.stop_cond();
    endtask : write_seq

    task automatic read_seq(input logic set_addr, input logic [6:0] addr, input int n);
        logic [7:0] q;
        logic       a;
        if (set_addr) begin
            master.start_cond();
            send(8'hde, 1'b1);
            send({1'b0, addr}, 1'b1);
            ref_ptr = addr;
        end
        master.start_cond();
        send(8'hdf, 1'b1);
        for (int i = 0; i < n; i++) begin
            master.xfer(8'hff, i == n - 1, q, a);
            check("read data", q, ref_mem[ref_ptr]);
            ref_ptr = nxt(ref_ptr);
        end
        master.stop_cond();
    endtask : read_seq

    task automatic give_verdict();
        if (fail_count == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : give_verdict

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        repeat (90000) @(posedge core_clk);
        fail_count++;
        give_verdict();
    end

    initial begin
        reset = 1'b1;
        fail_count = 0;
        comparisons = 0;
        // The first current-address read relies on the pointer's value after reset.
        ref_ptr = PTR_RESET;
        void'($urandom(32'h79a43030));
        for (int i = 0; i < 32; i++) begin
            tk_regs[i] = 8'($urandom);
            ref_mem[i] = tk_regs[i];
        end
        repeat (16) @(negedge core_clk);
        reset = 1'b0;
        repeat (4) @(negedge core_clk);
        // A foreign target address must leave the pointer at its reset value.
        master.start_cond();
        send(8'ha0, 1'b0);
        master.stop_cond();
        read_seq(1'b0, 7'h00, 1);
        write_seq(7'h3b, 70);
        read_seq(1'b0, 7'h00, 2);
        read_seq(1'b1, 7'h5f, 3);
        read_seq(1'b0, 7'h00, 1);
        write_seq(7'h1e, 3);
        read_seq(1'b1, 7'h1e, 3);
        // Out-of-range writes: neither address nor data may be taken.
        for (int k = 0; k < 2; k++) begin
            master.start_cond();
            send(8'hde, 1'b1);
            send(k == 0 ? 8'h60 : 8'h7f, 1'b0);
            send(8'($urandom), 1'b0);
            master.stop_cond();
        end
        read_seq(1'b0, 7'h00, 1);
        // A full block read also catches any aliasing from the refused writes.
        read_seq(1'b1, 7'h20, 64);
        for (int k = 0; k < 6; k++) begin
            write_seq(7'($urandom_range(0, 95)), 1);
            read_seq(1'b0, 7'h00, 1);
        end
        give_verdict();
    end

endmodule : rtc_sram_i2c_access_test
